// [bench/iord_core_model.sv]
`timescale 1ns/1ns
// ***********
// core side issuing io accesses
// ***********
module iord_core_model (
	input wire logic sys_clk,
	output iord_pkg::iord_req_t req
);
	// idle until the first access
	initial req = '0;
	// one access per call, then an idle cycle so answers never overlap
	task automatic access(input iord_pkg::iord_op_t op, input logic [7:0] a,
		input logic [2:0] b, input logic [7:0] d);
		@(posedge sys_clk);
		#1 req = '{op, a, b, d};
		@(posedge sys_clk);
		#1 req.op = iord_pkg::IORD_NONE;
	endtask : access
endmodule : iord_core_model

// [bench/iord_space_asserts.sv]
`timescale 1ns/1ns
// ***********
// io space checks
// ***********
module iord_space_asserts (
	input wire logic sys_clk,
	input wire logic rst,
	input wire iord_pkg::iord_req_t req,
	input wire iord_pkg::iord_rsp_t rsp,
	input wire logic [7:0] tmr0Set,
	input wire logic [7:0] outA,
	input wire logic [7:0] dirB,
	input wire logic [7:0] regFileView [0:63],
	input wire logic extSel
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// request decode
	wire isOut = req.op == iord_pkg::IORD_OUT;
	wire isSet = req.op == iord_pkg::IORD_BSET;
	wire isLd = req.op == iord_pkg::IORD_LOAD;
	wire isSv = req.op == iord_pkg::IORD_SAVE;
	wire isClr = req.op == iord_pkg::IORD_BCLR;
	wire isTst = req.op == iord_pkg::IORD_BTEST;
	chk_bit_set:
	assert property (isSet && req.addr == 8'h02 |=> outA[$past(req.bitSel)])
		else $error("bit set missed");
	chk_bit_clear:
	assert property (isClr && req.addr == 8'h02 |=> !outA[$past(req.bitSel)])
		else $error("bit clear missed");
	chk_skip_bit:
	assert property (isTst && req.addr == 8'h00
		|=> rsp.bitVal == $past(regFileView[0][req.bitSel]))
		else $error("test bit wrong");
	chk_flag_w1c:
	assert property (isOut && req.addr == 8'h15 && req.wdata[0]
		&& !tmr0Set[0] |=> !regFileView[21][0]) else $error("flag kept");
	chk_bitop_rmw:
	assert property (isSet && req.addr == 8'h15 && !tmr0Set[0]
		|=> !regFileView[21][0]) else $error("bit op kept flag");
	chk_bit_range:
	assert property ((isSet || isClr || isTst) && req.addr > 8'h1f
		|=> !rsp.hit) else $error("bit op out of range hit");
	chk_io_write:
	assert property (isOut && req.addr == 8'h04 |=> dirB == $past(req.wdata))
		else $error("io write lost");
	chk_data_view:
	assert property (isSv && req.addr == 8'h24 |=> dirB == $past(req.wdata))
		else $error("data write lost");
	chk_ext_only:
	assert property (extSel == ((isLd || isSv) && req.addr >= 8'h60))
		else $error("ext select wrong");
	chk_resv_zero:
	assert property (req.op == iord_pkg::IORD_IN && req.addr == 8'h0c
		|=> rsp.rdata == 8'h00) else $error("reserved read not zero");
endmodule : iord_space_asserts
bind iord_space iord_space_asserts iord_space_asserts_i (.sys_clk, .rst,
	.req, .rsp, .tmr0Set, .outA, .dirB, .regFileView, .extSel);

// [bench/iord_space_tb_top.sv]
`timescale 1ns/1ns
// ***********
// io space decoder bench
// ***********
module iord_space_tb_top;
	logic sys_clk;
	logic rst = 1'b1;
	logic [7:0] port_a_input_pins = 8'h10, port_b_input_pins = 8'h5a, port_c_input_pins = 8'hc3, port_d_input_pins = 8'h0f;
	logic [7:0] fSet [0:7] = '{default: 8'h00};
	logic acmpOut = 1'b0;
	logic [7:0] dirA, outA, dirB, outB, dirC, outC, dirD, outD, extAddr;
	logic [7:0] regFileView [0:63];
	logic extSel;
	iord_pkg::iord_req_t req;
	iord_pkg::iord_rsp_t rsp;
	int error_cnt = 0, n_tests = 0, cyc = 0;
	iord_core_model iord_core_model_i (.sys_clk, .req);
	// every event input has its own pulse slot
	iord_space iord_space_i (.sys_clk, .rst, .req, .rsp, .port_a_input_pins, .port_b_input_pins, .port_c_input_pins,
		.port_d_input_pins, .tmr0Set(fSet[0]), .tmr1Set(fSet[1]), .tmr2Set(fSet[4]),
		.tmr3Set(fSet[5]), .pcSet(fSet[6]), .extSet(fSet[7]),
		.spiSet(fSet[2]),
		.acmpSet(fSet[3]), .acmpOut, .dirA, .outA, .dirB, .outB, .dirC, .outC,
		.dirD, .outD, .regFileView, .extSel, .extAddr);
	// shared helpers
	task automatic acc(input iord_pkg::iord_op_t op, input logic [7:0] a,
		input logic [2:0] b, input logic [7:0] d);
		iord_core_model_i.access(op, a, b, d);
	endtask : acc
	task automatic pulse(input int i, input logic [7:0] m);
		@(posedge sys_clk);
		#1 fSet[i] = m;
		@(posedge sys_clk);
		#1 fSet[i] = 8'h00;
	endtask : pulse
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	// scenarios
	task automatic t_io;
		acc(iord_pkg::IORD_OUT, 8'h04, 3'd0, 8'ha5);
		check(dirB, 8'ha5);
		acc(iord_pkg::IORD_LOAD, 8'h24, 3'd0, 8'h00);
		check(rsp.rdata, 8'ha5);
		acc(iord_pkg::IORD_SAVE, 8'h24, 3'd0, 8'h5a);
		check(dirB, 8'h5a);
		acc(iord_pkg::IORD_IN, 8'h0c, 3'd0, 8'h00);
		check(rsp.rdata, 8'h00);
		acc(iord_pkg::IORD_IN, 8'h60, 3'd0, 8'h00);
		check({7'h00, rsp.hit}, 8'h00);
		$display("t_io done");
	endtask : t_io
	task automatic t_bit;
		acc(iord_pkg::IORD_BSET, 8'h02, 3'd7, 8'h00);
		acc(iord_pkg::IORD_BSET, 8'h02, 3'd0, 8'h00);
		check(outA, 8'h81);
		acc(iord_pkg::IORD_BCLR, 8'h02, 3'd7, 8'h00);
		check(outA, 8'h01);
		acc(iord_pkg::IORD_BTEST, 8'h00, 3'd4, 8'h00);
		check({7'h00, rsp.bitVal}, 8'h01);
		acc(iord_pkg::IORD_BTEST, 8'h00, 3'd3, 8'h00);
		check({7'h00, rsp.bitVal}, 8'h00);
		acc(iord_pkg::IORD_BSET, 8'h1e, 3'd2, 8'h00);
		acc(iord_pkg::IORD_BSET, 8'h2a, 3'd2, 8'h00);
		acc(iord_pkg::IORD_IN, 8'h1e, 3'd0, 8'h00);
		check(rsp.rdata, 8'h04);
		acc(iord_pkg::IORD_IN, 8'h2a, 3'd0, 8'h00);
		check(rsp.rdata, 8'h00);
		pulse(0, 8'h03);
		acc(iord_pkg::IORD_BSET, 8'h15, 3'd2, 8'h00);
		acc(iord_pkg::IORD_IN, 8'h15, 3'd0, 8'h00);
		check(rsp.rdata, 8'h00);
		$display("t_bit done");
	endtask : t_bit
	task automatic t_port;
		acc(iord_pkg::IORD_OUT, 8'h01, 3'd0, 8'h11);
		acc(iord_pkg::IORD_OUT, 8'h05, 3'd0, 8'h22);
		acc(iord_pkg::IORD_OUT, 8'h07, 3'd0, 8'h33);
		acc(iord_pkg::IORD_OUT, 8'h08, 3'd0, 8'h44);
		acc(iord_pkg::IORD_SAVE, 8'h2a, 3'd0, 8'h55);
		acc(iord_pkg::IORD_SAVE, 8'h2b, 3'd0, 8'h66);
		check(dirA, 8'h11);
		check(outB, 8'h22);
		check(dirC, 8'h33);
		check(outC, 8'h44);
		check(dirD, 8'h55);
		check(outD, 8'h66);
		acc(iord_pkg::IORD_IN, 8'h03, 3'd0, 8'h00);
		check(rsp.rdata, 8'h5a);
		acc(iord_pkg::IORD_LOAD, 8'h26, 3'd0, 8'h00);
		check(rsp.rdata, 8'hc3);
		acc(iord_pkg::IORD_IN, 8'h09, 3'd0, 8'h00);
		check(rsp.rdata, 8'h0f);
		acc(iord_pkg::IORD_LOAD, 8'h1f, 3'd0, 8'h00);
		check({7'h00, rsp.hit}, 8'h00);
		acc(iord_pkg::IORD_OUT, 8'h23, 3'd0, 8'h83);
		acc(iord_pkg::IORD_IN, 8'h23, 3'd0, 8'h00);
		check(rsp.rdata, 8'h83);
		// events on missing flag bits must not show up
		pulse(7, 8'hff);
		acc(iord_pkg::IORD_IN, 8'h1c, 3'd0, 8'h00);
		check(rsp.rdata, 8'h07);
		acc(iord_pkg::IORD_OUT, 8'h1c, 3'd0, 8'h07);
		$display("t_port done");
	endtask : t_port
	// event and clear on the same edge: the event must survive
	task automatic t_race;
		fork
			pulse(0, 8'h01);
			acc(iord_pkg::IORD_OUT, 8'h15, 3'd0, 8'h01);
		join
		acc(iord_pkg::IORD_IN, 8'h15, 3'd0, 8'h00);
		check(rsp.rdata, 8'h01);
		acc(iord_pkg::IORD_OUT, 8'h15, 3'd0, 8'h01);
		acc(iord_pkg::IORD_IN, 8'h15, 3'd0, 8'h00);
		check(rsp.rdata, 8'h00);
		$display("t_race done");
	endtask : t_race
	task automatic t_w1c(input int i, input logic [7:0] a, input logic [7:0] m);
		pulse(i, m);
		acc(iord_pkg::IORD_OUT, a, 3'd0, 8'h00);
		acc(iord_pkg::IORD_IN, a, 3'd0, 8'h00);
		check(rsp.rdata, m);
		acc(iord_pkg::IORD_OUT, a, 3'd0, m);
		acc(iord_pkg::IORD_IN, a, 3'd0, 8'h00);
		check(rsp.rdata, 8'h00);
		$display("t_w1c done");
	endtask : t_w1c
	task automatic t_ext;
		acmpOut = 1'b1;
		fork
			acc(iord_pkg::IORD_SAVE, 8'h60, 3'd0, 8'h11);
			begin
				@(posedge sys_clk);
				#2 check({7'h00, extSel}, 8'h01);
				check(extAddr, 8'h60);
			end
		join
		acc(iord_pkg::IORD_IN, 8'h30, 3'd0, 8'h00);
		check(rsp.rdata, 8'h20);
		$display("t_ext done");
	endtask : t_ext
	// clock
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// hang guard, far above the 160 or so cycles the run needs
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			error_cnt++;
			stop_test();
		end
	end
	// main sequence
	initial
	begin
		repeat (2) @(posedge sys_clk);
		#1 rst = 1'b0;
		t_io();
		t_bit();
		t_port();
		t_w1c(0, 8'h15, 8'h07);
		t_w1c(1, 8'h16, 8'h27);
		t_w1c(2, 8'h2d, 8'hc0);
		t_w1c(3, 8'h30, 8'h10);
		t_w1c(4, 8'h17, 8'h07);
		t_w1c(5, 8'h18, 8'h27);
		t_w1c(6, 8'h1b, 8'h0f);
		t_w1c(7, 8'h1c, 8'h07);
		t_race();
		t_ext();
		stop_test();
	end
endmodule : iord_space_tb_top

// [design/iord_pkg.sv]
// ****************************************
// io register space constants and types
// ****************************************
package iord_pkg;
	localparam int DW = 8;
	localparam int IOAW = 6;
	localparam int DAW = 8;
	// io space window and data-space view
	localparam logic [7:0] IO_LAST = 8'h3f;
	localparam logic [7:0] BIT_LAST = 8'h1f;
	localparam logic [7:0] DATA_OFS = 8'h20;
	localparam logic [7:0] EXT_FIRST = 8'h60;
	// register offsets in io space
	localparam logic [5:0] A_PORT_A_INPUT_PINS = 6'h00;
	localparam logic [5:0] A_DIRA = 6'h01;
	localparam logic [5:0] A_OUTA = 6'h02;
	localparam logic [5:0] A_PORT_B_INPUT_PINS = 6'h03;
	localparam logic [5:0] A_DIRB = 6'h04;
	localparam logic [5:0] A_OUTB = 6'h05;
	localparam logic [5:0] A_PORT_C_INPUT_PINS = 6'h06;
	localparam logic [5:0] A_DIRC = 6'h07;
	localparam logic [5:0] A_OUTC = 6'h08;
	localparam logic [5:0] A_PORT_D_INPUT_PINS = 6'h09;
	localparam logic [5:0] A_DIRD = 6'h0a;
	localparam logic [5:0] A_OUTD = 6'h0b;
	localparam logic [5:0] A_TMF0 = 6'h15;
	localparam logic [5:0] A_TMF1 = 6'h16;
	localparam logic [5:0] A_TMF2 = 6'h17;
	localparam logic [5:0] A_TMF3 = 6'h18;
	localparam logic [5:0] A_PCF = 6'h1b;
	localparam logic [5:0] A_EXF = 6'h1c;
	localparam logic [5:0] A_SCR0 = 6'h1e;
	localparam logic [5:0] A_EECTL = 6'h1f;
	localparam logic [5:0] A_EEDAT = 6'h20;
	localparam logic [5:0] A_EEADL = 6'h21;
	localparam logic [5:0] A_EEADH = 6'h22;
	localparam logic [5:0] A_TGCTL = 6'h23;
	localparam logic [5:0] A_T0CA = 6'h24;
	localparam logic [5:0] A_T0CB = 6'h25;
	localparam logic [5:0] A_T0CNT = 6'h26;
	localparam logic [5:0] A_T0CMA = 6'h27;
	localparam logic [5:0] A_T0CMB = 6'h28;
	localparam logic [5:0] A_SCR1 = 6'h2a;
	localparam logic [5:0] A_SCR2 = 6'h2b;
	localparam logic [5:0] A_SPCTL = 6'h2c;
	localparam logic [5:0] A_SPST = 6'h2d;
	localparam logic [5:0] A_SPBUF = 6'h2e;
	localparam logic [5:0] A_ACMP = 6'h30;
	localparam logic [5:0] A_DBG = 6'h31;
	// implemented-bit masks, reserved bits read zero
	localparam logic [7:0] M_ALL = 8'hff;
	localparam logic [7:0] M_TMF0 = 8'h07;
	localparam logic [7:0] M_TMF13 = 8'h27;
	localparam logic [7:0] M_TMF2 = 8'h07;
	localparam logic [7:0] M_PCF = 8'h0f;
	localparam logic [7:0] M_EXF = 8'h07;
	localparam logic [7:0] M_EECTL = 8'h3f;
	localparam logic [7:0] M_EEADH = 8'h0f;
	localparam logic [7:0] M_TGCTL = 8'h83;
	localparam logic [7:0] M_T0CA = 8'hf3;
	localparam logic [7:0] M_T0CB = 8'hcf;
	localparam logic [7:0] M_SPST = 8'hc1;
	localparam logic [7:0] W1C_SPST = 8'hc0;
	localparam logic [7:0] W1C_ACMP = 8'h10;
	localparam logic [7:0] RO_ACMP = 8'h20;
	localparam logic [7:0] RST_VAL = 8'h00;
	// one core access to the io space
	typedef enum logic [2:0] {
		IORD_NONE, IORD_IN, IORD_OUT, IORD_LOAD, IORD_SAVE,
		IORD_BSET, IORD_BCLR, IORD_BTEST
	} iord_op_t;
	typedef struct packed {
		iord_op_t op;
		logic [7:0] addr;
		logic [2:0] bitSel;
		logic [7:0] wdata;
	} iord_req_t;
	typedef struct packed {
		logic [7:0] rdata;
		logic bitVal;
		logic hit;
	} iord_rsp_t;
endpackage : iord_pkg

// [design/iord_reg.sv]
`timescale 1ns/1ns
// ****************************************
// one register: plain bits, w1c flags, hardware sets
// ****************************************
module iord_reg #(
	parameter logic [7:0] MASK = 8'hff,
	parameter logic [7:0] W1C = 8'h00,
	parameter logic [7:0] RO = 8'h00
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wrEn,
	input wire logic [7:0] wrData,
	input wire logic [7:0] hwSet,
	input wire logic [7:0] hwVal,
	output logic [7:0] value
);
	logic [7:0] val_ff;
	logic [7:0] nxt_val;
	wire [7:0] plainMask = MASK & ~W1C & ~RO;
	wire [7:0] clrMask = wrEn ? (wrData & W1C) : 8'h00;
	wire [7:0] plainNew = wrEn ? wrData : val_ff;
	// flags: set beats a same-cycle clear
	assign nxt_val = (((plainNew & plainMask)
		| (val_ff & W1C & ~clrMask) | (hwSet & W1C))
		| (hwVal & RO)) & MASK;
	// state
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			val_ff <= iord_pkg::RST_VAL;
		else
			val_ff <= nxt_val;
	end
	assign value = val_ff;
endmodule : iord_reg

// [design/iord_space.sv]
`timescale 1ns/1ns
module iord_space (
	input wire logic sys_clk,
	input wire logic rst,
	input wire iord_pkg::iord_req_t req,
	output iord_pkg::iord_rsp_t rsp,
	input wire logic [7:0] port_a_input_pins,
	input wire logic [7:0] port_b_input_pins,
	input wire logic [7:0] port_c_input_pins,
	input wire logic [7:0] port_d_input_pins,
	input wire logic [7:0] tmr0Set,
	input wire logic [7:0] tmr1Set,
	input wire logic [7:0] tmr2Set,
	input wire logic [7:0] tmr3Set,
	input wire logic [7:0] pcSet,
	input wire logic [7:0] extSet,
	input wire logic [7:0] spiSet,
	input wire logic [7:0] acmpSet,
	input wire logic acmpOut,
	output logic [7:0] dirA,
	output logic [7:0] outA,
	output logic [7:0] dirB,
	output logic [7:0] outB,
	output logic [7:0] dirC,
	output logic [7:0] outC,
	output logic [7:0] dirD,
	output logic [7:0] outD,
	output logic [7:0] regFileView [0:63],
	output logic extSel,
	output logic [7:0] extAddr
);
	// ****************************************
	// address decode
	// ****************************************
	// io-instruction forms carry the io address directly
	wire isIo = req.op == iord_pkg::IORD_IN
		|| req.op == iord_pkg::IORD_OUT;
	wire isBit = req.op == iord_pkg::IORD_BSET
		|| req.op == iord_pkg::IORD_BCLR
		|| req.op == iord_pkg::IORD_BTEST;
	wire isData = req.op == iord_pkg::IORD_LOAD
		|| req.op == iord_pkg::IORD_SAVE;
	// data view is shifted by the fixed offset
	wire [7:0] dataIoAddr = req.addr - iord_pkg::DATA_OFS;
	wire dataInIo = req.addr >= iord_pkg::DATA_OFS
		&& req.addr < iord_pkg::EXT_FIRST;
	wire ioInRange = req.addr <= iord_pkg::IO_LAST;
	wire bitInRange = req.addr <= iord_pkg::BIT_LAST;
	wire ioHit = (isIo && ioInRange) || (isData && dataInIo)
		|| (isBit && bitInRange);
	wire [5:0] ioAddr = isData ? dataIoAddr[5:0] : req.addr[5:0];
	// extended space is for load/save only
	assign extSel = isData && req.addr >= iord_pkg::EXT_FIRST;
	assign extAddr = req.addr;
	// ****************************************
	// read side of the register file
	// ****************************************
	logic [7:0] regs [0:63];
	logic [7:0] curVal;
	assign curVal = regs[ioAddr];
	assign regFileView = regs;
	// bit op = read, modify one bit, write whole register back
	wire [7:0] bitMask = 8'h01 << req.bitSel;
	wire [7:0] rmwVal = req.op == iord_pkg::IORD_BSET
		? (curVal | bitMask) : (curVal & ~bitMask);
	wire bitWr = (req.op == iord_pkg::IORD_BSET
		|| req.op == iord_pkg::IORD_BCLR) && bitInRange;
	wire plainWr = (req.op == iord_pkg::IORD_OUT && ioInRange)
		|| (req.op == iord_pkg::IORD_SAVE && dataInIo);
	wire wrAny = bitWr || plainWr;
	wire [7:0] wrData = bitWr ? rmwVal : req.wdata;
	// ****************************************
	// registers
	// ****************************************
	localparam int NREG = 33;
	localparam logic [5:0] ADDRS [0:NREG-1] = '{
		iord_pkg::A_DIRA, iord_pkg::A_OUTA, iord_pkg::A_DIRB,
		iord_pkg::A_OUTB, iord_pkg::A_DIRC, iord_pkg::A_OUTC,
		iord_pkg::A_DIRD, iord_pkg::A_OUTD, iord_pkg::A_TMF0,
		iord_pkg::A_TMF1, iord_pkg::A_TMF2, iord_pkg::A_TMF3,
		iord_pkg::A_PCF, iord_pkg::A_EXF, iord_pkg::A_SCR0,
		iord_pkg::A_EECTL, iord_pkg::A_EEDAT, iord_pkg::A_EEADL,
		iord_pkg::A_EEADH, iord_pkg::A_TGCTL, iord_pkg::A_T0CA,
		iord_pkg::A_T0CB, iord_pkg::A_T0CNT, iord_pkg::A_T0CMA,
		iord_pkg::A_T0CMB, iord_pkg::A_SCR1, iord_pkg::A_SCR2,
		iord_pkg::A_SPCTL, iord_pkg::A_SPST, iord_pkg::A_SPBUF,
		iord_pkg::A_ACMP, iord_pkg::A_DBG, iord_pkg::A_PORT_A_INPUT_PINS};
	localparam logic [7:0] MASKS [0:NREG-1] = '{
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		iord_pkg::M_TMF0, iord_pkg::M_TMF13, iord_pkg::M_TMF2,
		iord_pkg::M_TMF13, iord_pkg::M_PCF, iord_pkg::M_EXF,
		8'hff, iord_pkg::M_EECTL, 8'hff, 8'hff, iord_pkg::M_EEADH,
		iord_pkg::M_TGCTL, iord_pkg::M_T0CA, iord_pkg::M_T0CB,
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		iord_pkg::M_SPST, 8'hff, 8'hff, 8'hff, 8'h00};
	// w1c sets: timer/pin/ext flag registers whole, SPST and ACMP partial, the rest none
	localparam logic [7:0] W1CS [0:NREG-1] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		iord_pkg::W1C_SPST, 8'h00, iord_pkg::W1C_ACMP, 8'h00, 8'h00};
	logic [7:0] hwSetV [0:NREG-1];
	logic [7:0] hwValV [0:NREG-1];
	logic [7:0] valV [0:NREG-1];
	// hardware event and status inputs per register
	always_comb
	begin
		for (int i = 0; i < NREG; i++)
		begin
			hwSetV[i] = 8'h00;
			hwValV[i] = 8'h00;
		end
		hwSetV[8] = tmr0Set;
		hwSetV[9] = tmr1Set;
		hwSetV[10] = tmr2Set;
		hwSetV[11] = tmr3Set;
		hwSetV[12] = pcSet;
		hwSetV[13] = extSet;
		hwSetV[28] = spiSet;
		hwSetV[30] = acmpSet;
		hwValV[30] = acmpOut ? iord_pkg::RO_ACMP : 8'h00;
	end
	genvar g;
	generate
		for (g = 0; g < NREG - 1; g++)
		begin : gReg
			iord_reg #(
				.MASK(MASKS[g]),
				.W1C(W1CS[g]),
				.RO(g == 30 ? iord_pkg::RO_ACMP : 8'h00)
			) uReg (
				.sys_clk(sys_clk),
				.rst(rst),
				.wrEn(wrAny && ioAddr == ADDRS[g]),
				.wrData(wrData),
				.hwSet(hwSetV[g]),
				.hwVal(hwValV[g]),
				.value(valV[g])
			);
		end
	endgenerate
	assign valV[NREG-1] = 8'h00;
	// ****************************************
	// map into the 64-entry io space
	// ****************************************
	// pin registers mirror the pins; unmapped slots read zero
	always_comb
	begin
		for (int a = 0; a < 64; a++)
			regs[a] = 8'h00;
		for (int i = 0; i < NREG - 1; i++)
			regs[ADDRS[i]] = valV[i];
		regs[iord_pkg::A_PORT_A_INPUT_PINS] = port_a_input_pins;
		regs[iord_pkg::A_PORT_B_INPUT_PINS] = port_b_input_pins;
		regs[iord_pkg::A_PORT_C_INPUT_PINS] = port_c_input_pins;
		regs[iord_pkg::A_PORT_D_INPUT_PINS] = port_d_input_pins;
	end
	assign dirA = valV[0];
	assign outA = valV[1];
	assign dirB = valV[2];
	assign outB = valV[3];
	assign dirC = valV[4];
	assign outC = valV[5];
	assign dirD = valV[6];
	assign outD = valV[7];
	// ****************************************
	// answer, registered
	// ****************************************
	iord_pkg::iord_rsp_t rsp_ff;
	iord_pkg::iord_rsp_t nxt_rsp;
	assign nxt_rsp.rdata = ioHit ? curVal : 8'h00;
	assign nxt_rsp.bitVal = req.op == iord_pkg::IORD_BTEST
		&& bitInRange && curVal[req.bitSel];
	assign nxt_rsp.hit = ioHit;
	// one-cycle read latency
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			rsp_ff <= '0;
		else
			rsp_ff <= nxt_rsp;
	end
	assign rsp = rsp_ff;
endmodule : iord_space
